// file: src/pd_sideband_pkg.sv
/*
  Package for the PD sideband block: timing, addresses, capability words,
  and the carrier structs shared by the top module.
  Assumes a single 250 MHz clock and a synchronous active-high reset.
*/
`default_nettype none

package pd_sideband_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_PS = 4000;      // 4 ns period
  localparam int unsigned RAIL_SETTLE_US = 100;      // Least time after rail up
  // Least time rounds up to whole cycles
  localparam int unsigned RAIL_SETTLE_CYC =
    (RAIL_SETTLE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ****************************************************************
  // Secondary target port addresses
  // ****************************************************************
  localparam logic [6:0] ADDR_PORT_A = 7'h38;        // Port A status
  localparam logic [6:0] ADDR_PORT_B = 7'h3F;        // Port B status

  // ****************************************************************
  // Capability words: voltage in 50 mV units, current in 10 mA units
  // ****************************************************************
  localparam logic [9:0] SRC_V_5V = 10'h064;         // 5 V
  localparam logic [9:0] SRC_I_1A5 = 10'h096;        // 1.5 A
  localparam logic [9:0] SNK_V_5V = 10'h064;         // 5 V
  localparam logic [9:0] SNK_V_9V = 10'h0B4;         // 9 V
  localparam logic [9:0] SNK_V_15V = 10'h12C;        // 15 V
  localparam logic [9:0] SNK_V_20V = 10'h190;        // 20 V
  localparam logic [9:0] SNK_I_3A = 10'h12C;         // 3 A

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic RST_COMPANION_N = 1'b0;           // Companion held in reset
  localparam logic [7:0] RST_STATUS = 8'h00;         // No data connection

  // Sequencer states
  typedef enum logic [1:0] {
    SEQ_LOAD   = 2'b00,  // Own configuration load
    SEQ_WAIT   = 2'b01,  // Waiting on rail and settle time
    SEQ_ACTIVE = 2'b10   // Companion released
  } seq_e;

  // Port event group from the policy engine
  typedef struct packed {
    logic flip;        // Cable orientation
    logic dp_mode;     // Display mode selected
    logic tunnel;      // High-speed tunnelling entered
  } port_evt_s;

  // SBU mux controls
  typedef struct packed {
    logic a_sel;       // sbu_a_path_select
    logic b_sel;       // sbu_b_path_select
    logic aux_on;      // sbu_aux_path_on
    logic ls_on;       // sbu_lowspeed_path_on
  } sbu_ctl_s;

endpackage : pd_sideband_pkg

`default_nettype wire

// file: src/pd_sideband.sv
/*
  PD sideband top: companion reset sequencing after configuration load,
  a dual-address I2C target for per-port status with a shared interrupt,
  and SBU mux control from port 0 events.
  Assumes the flash loader, policy engine and primary controller port are
  outside; I2C pins arrive asynchronously and are open drain.
*/
`default_nettype none

// Notes on behaviour
// - Device reads shared flash before companion
// - Hold companion reset until config loaded
// - Pin zero only drives companion reset
// - Release 100 us after companion rail
// - Target answers addresses 38h and 3Fh
// - First address port A, second port B
// - One shared interrupt for both ports
// - Port 0 events drive SBU mux
// - Primary port controls SoC data unit
// - Controller reaches device via target port
// - Source offers 5 V at 1.5 A
// - Sink offers 5/9/15/20 V at 3 A

module pd_sideband
  import pd_sideband_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = RAIL_SETTLE_CYC  // Shorten in simulation
) (
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire logic I_CFG_DONE,            // Own config load finished
  input wire logic I_COMPANION_3V3_RAIL,  // Companion supply good (async)
  input wire logic I_BOOT_GATE_EN,        // Controller asks to wait for boot
  input wire logic I_SYS_BOOTED,          // System boot finished
  input wire port_evt_s I_PORT0_EVT,      // Port 0 events
  input wire logic [7:0] I_STAT_A,        // Port A data status
  input wire logic [7:0] I_STAT_B,        // Port B data status
  input wire logic I_STAT_CHG,            // Pulse: status changed
  input wire logic I_SCL,                 // Target clock pin
  input wire logic I_SDA,                 // Target data pin in
  output logic O_SDA_OE,                  // Pull data low when high
  output logic O_SDA,                     // Always low when enabled
  output logic O_COMPANION_RST_LINE_N,    // Companion reset, active low
  output logic O_FLASH_GRANT_COMPANION,   // Companion may use flash
  output logic O_IRQ_N,                   // Shared interrupt, active low
  output logic [9:0] O_SRC_V,             // Source offer voltage
  output logic [9:0] O_SRC_I,             // Source offer current
  output logic [39:0] O_SNK_V,            // Four sink voltages
  output logic [9:0] O_SNK_I,             // Sink current
  output sbu_ctl_s O_SBU                  // SBU mux controls
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Three stages; a change counts when stages two and three agree
  logic [2:0] rail_sync_ff;
  logic [2:0] scl_sync_ff;
  logic [2:0] sda_sync_ff;
  logic rail_ok_ff;
  logic scl_ff;
  logic sda_ff;

  // Shift in pin levels
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      rail_sync_ff <= 3'h0;
      scl_sync_ff <= 3'h7;
      sda_sync_ff <= 3'h7;
    end else begin
      rail_sync_ff <= {rail_sync_ff[1:0], I_COMPANION_3V3_RAIL};
      scl_sync_ff <= {scl_sync_ff[1:0], I_SCL};
      sda_sync_ff <= {sda_sync_ff[1:0], I_SDA};
    end
  end

  // Filtered levels update only on agreement
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      rail_ok_ff <= 1'b0;
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
    end else begin
      if (rail_sync_ff[1] == rail_sync_ff[2]) begin
        rail_ok_ff <= rail_sync_ff[2];
      end
      if (scl_sync_ff[1] == scl_sync_ff[2]) begin
        scl_ff <= scl_sync_ff[2];
      end
      if (sda_sync_ff[1] == sda_sync_ff[2]) begin
        sda_ff <= sda_sync_ff[2];
      end
    end
  end

  // ****************************************************************
  // Companion reset sequencer
  // ****************************************************************
  seq_e seq_ff;
  seq_e nxt_seq;
  logic [31:0] settle_cnt_ff;
  logic settle_done;
  logic boot_ok;

  assign settle_done = (settle_cnt_ff >= SETTLE_CYC);
  assign boot_ok = !I_BOOT_GATE_EN || I_SYS_BOOTED;

  // Next state; losing the rail in SEQ_ACTIVE falls back to waiting
  always_comb begin
    nxt_seq = seq_ff;
    unique case (seq_ff)
      SEQ_LOAD: begin
        if (I_CFG_DONE) begin
          nxt_seq = SEQ_WAIT;
        end
      end
      SEQ_WAIT: begin
        if (rail_ok_ff && settle_done && boot_ok) begin
          nxt_seq = SEQ_ACTIVE;
        end
      end
      SEQ_ACTIVE: begin
        if (!rail_ok_ff) begin
          nxt_seq = SEQ_WAIT;
        end
      end
      // Unused code: start over and hold the companion
      default: begin
        nxt_seq = SEQ_LOAD;
      end
    endcase
  end

  // State register
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      seq_ff <= SEQ_LOAD;
    end else begin
      seq_ff <= nxt_seq;
    end
  end

  // Settle counter restarts whenever the rail drops
  always_ff @(posedge I_MCLK) begin
    if (I_RST || !rail_ok_ff) begin
      settle_cnt_ff <= 32'h0;
    end else if (!settle_done) begin
      settle_cnt_ff <= settle_cnt_ff + 32'h1;
    end
  end

  // Reset line and flash ownership
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      O_COMPANION_RST_LINE_N <= RST_COMPANION_N;
      O_FLASH_GRANT_COMPANION <= 1'b0;
    end else begin
      O_COMPANION_RST_LINE_N <= (nxt_seq == SEQ_ACTIVE);
      O_FLASH_GRANT_COMPANION <= (nxt_seq != SEQ_LOAD);
    end
  end

  // ****************************************************************
  // Secondary target port
  // ****************************************************************
  // Read-only status target; writes are acknowledged and dropped
  logic scl_d_ff;
  logic sda_d_ff;
  logic active_ff;       // Inside a transaction
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic addr_phase_ff;
  logic ack_ff;          // In an ack slot, ours or the controller's after read data
  logic rd_ff;           // Read transaction
  logic sel_b_ff;        // Port B selected
  logic send_ff;         // Driving data bits
  logic [7:0] tx_ff;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;

  assign scl_rise = scl_ff && !scl_d_ff;
  assign scl_fall = !scl_ff && scl_d_ff;
  assign start_c = scl_ff && scl_d_ff && sda_d_ff && !sda_ff;
  assign stop_c = scl_ff && scl_d_ff && !sda_d_ff && sda_ff;

  // Delayed copies for edge detection
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl_ff;
      sda_d_ff <= sda_ff;
    end
  end

  // Bit engine
  always_ff @(posedge I_MCLK) begin
    if (I_RST || stop_c) begin
      active_ff <= 1'b0;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      addr_phase_ff <= 1'b0;
      ack_ff <= 1'b0;
      rd_ff <= 1'b0;
      sel_b_ff <= 1'b0;
      send_ff <= 1'b0;
      tx_ff <= 8'h00;
    end else if (start_c) begin
      active_ff <= 1'b1;
      bit_cnt_ff <= 4'h0;
      addr_phase_ff <= 1'b1;
      ack_ff <= 1'b0;
      send_ff <= 1'b0;
    end else if (active_ff && scl_rise && !ack_ff && !send_ff) begin
      shift_ff <= {shift_ff[6:0], sda_ff};
      bit_cnt_ff <= bit_cnt_ff + 4'h1;
    end else if (active_ff && scl_rise && send_ff) begin
      bit_cnt_ff <= bit_cnt_ff + 4'h1;
    end else if (active_ff && scl_rise && ack_ff && rd_ff && !addr_phase_ff) begin
      // Controller's ack on read data; nack ends our drive
      if (sda_ff) begin
        active_ff <= 1'b0;
      end
    end else if (active_ff && scl_fall) begin
      if (ack_ff) begin
        // End of ack slot
        ack_ff <= 1'b0;
        addr_phase_ff <= 1'b0;
        bit_cnt_ff <= 4'h0;
        send_ff <= rd_ff;
        if (rd_ff) begin
          tx_ff <= sel_b_ff ? I_STAT_B : I_STAT_A;
        end
      end else if (send_ff && bit_cnt_ff == 4'h8) begin
        send_ff <= 1'b0;
        ack_ff <= 1'b1;
      end else if (send_ff) begin
        tx_ff <= {tx_ff[6:0], 1'b0};
      end else if (bit_cnt_ff == 4'h8) begin
        if (addr_phase_ff) begin
          if (shift_ff[7:1] == ADDR_PORT_A || shift_ff[7:1] == ADDR_PORT_B) begin
            ack_ff <= 1'b1;
            rd_ff <= shift_ff[0];
            sel_b_ff <= (shift_ff[7:1] == ADDR_PORT_B);
          end else begin
            active_ff <= 1'b0;
          end
        end else begin
          ack_ff <= 1'b1;
        end
      end
    end
  end

  // Data pin drive: ack low in address and write-data ack slots, data bits on reads
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      O_SDA_OE <= 1'b0;
      O_SDA <= 1'b0;
    end else begin
      O_SDA <= 1'b0;
      // A data bit stands until the clock falls; letting go while
      // the clock is high would look like a stop to the controller
      O_SDA_OE <= active_ff && ((ack_ff && (addr_phase_ff || !rd_ff)) ||
                  (send_ff && !tx_ff[7]));
    end
  end

  // ****************************************************************
  // Shared interrupt
  // ****************************************************************
  // One line for both ports; set wins over read clear
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      O_IRQ_N <= 1'b1;
    end else if (I_STAT_CHG) begin
      O_IRQ_N <= 1'b0;
    end else if (ack_ff && rd_ff && addr_phase_ff && scl_fall) begin
      O_IRQ_N <= 1'b1;
    end
  end

  // ****************************************************************
  // SBU mux and capability words
  // ****************************************************************
  // Port 0 events to mux
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      O_SBU <= '0;
    end else begin
      O_SBU.a_sel <= I_PORT0_EVT.flip;
      O_SBU.b_sel <= I_PORT0_EVT.flip;
      O_SBU.aux_on <= I_PORT0_EVT.dp_mode;
      O_SBU.ls_on <= I_PORT0_EVT.tunnel;
    end
  end

  // Fixed offers; is served by the external primary port
  always_ff @(posedge I_MCLK) begin
    O_SRC_V <= SRC_V_5V;
    O_SRC_I <= SRC_I_1A5;
    O_SNK_V <= {SNK_V_20V, SNK_V_15V, SNK_V_9V, SNK_V_5V};
    O_SNK_I <= SNK_I_3A;
  end

endmodule : pd_sideband

`default_nettype wire

// file: test/pd_sideband_assertions.sv
/* Concurrent checks on the ports of pd_sideband.
   Assumes one clock domain and the package constants. */
`default_nettype none
module pd_sideband_chk
  import pd_sideband_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = RAIL_SETTLE_CYC
) (
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire logic I_CFG_DONE,
  input wire logic I_COMPANION_3V3_RAIL,
  input wire logic I_BOOT_GATE_EN,
  input wire logic I_SYS_BOOTED,
  input wire port_evt_s I_PORT0_EVT,
  input wire logic I_STAT_CHG,
  input wire logic O_SDA_OE,
  input wire logic O_COMPANION_RST_LINE_N,
  input wire logic O_FLASH_GRANT_COMPANION,
  input wire logic O_IRQ_N,
  input wire sbu_ctl_s O_SBU
);
  logic [31:0] rail_cnt_ff; // Cycles the rail has stood high
  // Saturating count, cleared whenever the rail drops
  always_ff @(posedge I_MCLK) begin
    if (!I_COMPANION_3V3_RAIL) begin
      rail_cnt_ff <= 32'h0;
    end else if (rail_cnt_ff != 32'hFFFFFFFF) begin
      rail_cnt_ff <= rail_cnt_ff + 32'h1;
    end
  end
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (I_RST);
  // Companion reset line going from held to released
  sequence s_release;
    !O_COMPANION_RST_LINE_N ##1 O_COMPANION_RST_LINE_N;
  endsequence
  a_release_after_rail: assert property (s_release |-> rail_cnt_ff >= SETTLE_CYC)
    else $error("companion released too soon after rail");
  a_hold_until_load: assert property (
    !O_FLASH_GRANT_COMPANION |-> !O_COMPANION_RST_LINE_N)
    else $error("companion released before config load");
  // Reset still sampled high on the edge that releases it
  a_grant_take: assert property (
    !I_RST && I_CFG_DONE && !O_FLASH_GRANT_COMPANION |=> O_FLASH_GRANT_COMPANION)
    else $error("flash grant late");
  a_grant_sticky: assert property (
    O_FLASH_GRANT_COMPANION |=> O_FLASH_GRANT_COMPANION)
    else $error("flash grant withdrawn");
  a_boot_wait: assert property (
    $rose(O_COMPANION_RST_LINE_N) |-> !$past(I_BOOT_GATE_EN) || $past(I_SYS_BOOTED))
    else $error("release before boot");
  a_irq_raise: assert property (I_STAT_CHG |=> !O_IRQ_N)
    else $error("interrupt not raised");
  a_sbu_track: assert property (
    !$past(I_RST) |-> O_SBU == {$past(I_PORT0_EVT.flip), $past(I_PORT0_EVT.flip),
                                $past(I_PORT0_EVT.dp_mode), $past(I_PORT0_EVT.tunnel)})
    else $error("sbu mux does not follow events");
  a_reset_values: assert property (
    $fell(I_RST) |-> !O_COMPANION_RST_LINE_N && !O_FLASH_GRANT_COMPANION && O_IRQ_N &&
                     !O_SDA_OE && O_SBU == 4'h0)
    else $error("outputs not at reset values");
endmodule : pd_sideband_chk
bind pd_sideband pd_sideband_chk #(.SETTLE_CYC(SETTLE_CYC)) chk_u (.I_MCLK(I_MCLK), .I_RST(I_RST),
  .I_CFG_DONE(I_CFG_DONE), .I_COMPANION_3V3_RAIL(I_COMPANION_3V3_RAIL),
  .I_BOOT_GATE_EN(I_BOOT_GATE_EN), .I_SYS_BOOTED(I_SYS_BOOTED), .I_PORT0_EVT(I_PORT0_EVT),
  .I_STAT_CHG(I_STAT_CHG), .O_SDA_OE(O_SDA_OE), .O_COMPANION_RST_LINE_N(O_COMPANION_RST_LINE_N),
  .O_FLASH_GRANT_COMPANION(O_FLASH_GRANT_COMPANION), .O_IRQ_N(O_IRQ_N), .O_SBU(O_SBU));
`default_nettype wire

// file: test/sb_companion_model.sv
/* Companion controller model on the secondary target port.
   Assumes a pull-up on SDA; a 1 on o_sda means released. */
`default_nettype none
module sb_companion_model (
  input wire logic i_clk,
  input wire logic i_sda_line,
  output var logic o_scl,
  output var logic o_sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bus idles released
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // Quarter of an SCL period
  task automatic q();
    repeat (8) @(posedge i_clk);
  endtask : q
  task automatic bit_io(input logic b, output logic r);
    o_sda <= b;
    q();
    o_scl <= 1'b1;
    q();
    r = i_sda_line;
    q();
    o_scl <= 1'b0;
    q();
  endtask : bit_io
  task automatic xfer(input logic [6:0] addr, input logic rd, input logic [7:0] wd,
                      output logic ack, output logic [7:0] d);
    logic r;
    logic [7:0] a;
    a = {addr, rd};
    d = 8'h00;
    o_sda <= 1'b0;
    q();
    o_scl <= 1'b0;
    q();
    for (int i = 7; i >= 0; i--) begin
      bit_io(a[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
    // Data only follows an acknowledged address
    if (ack) begin
      for (int i = 7; i >= 0; i--) begin
        bit_io(rd ? 1'b1 : wd[i], r);
        d = {d[6:0], r};
      end
      // Reads end on a nack; writes take the target's ack here
      bit_io(1'b1, r);
      if (!rd) begin
        ack = !r;
      end
    end
    o_sda <= 1'b0;
    q();
    o_scl <= 1'b1;
    q();
    o_sda <= 1'b1;
    q();
  endtask : xfer
endmodule : sb_companion_model
`default_nettype wire

// file: test/pd_sideband_tb_top.sv
/* Self-checking bench for pd_sideband.
   Assumes the companion model and the bound checker. */
`default_nettype none
module pd_sideband_tb_top
  import pd_sideband_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned SETTLE = 20; // Short settle keeps the run brief
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cfg_done = 1'b0;
  logic rail = 1'b0;
  logic gate_en = 1'b1; // Boot gate on for the whole run
  logic booted = 1'b0;
  logic chg = 1'b0;
  port_evt_s evt = '0;
  logic [7:0] stat_a = 8'h00;
  logic [7:0] stat_b = 8'h00;
  logic scl, mdl_sda, sda_oe, sda_o, rst_n, grant, irq_n;
  logic [9:0] src_v, src_i, snk_i;
  logic [39:0] snk_v;
  sbu_ctl_s sbu;
  wire logic sda_line;
  int miscompares = 0;
  int comparisons = 0;
  always #2 clk = ~clk;
  // Open-drain data line with pull-up
  assign sda_line = mdl_sda & ~(sda_oe & ~sda_o);
  pd_sideband #(.SETTLE_CYC(SETTLE)) dut_u (.I_MCLK(clk), .I_RST(rst), .I_CFG_DONE(cfg_done),
    .I_COMPANION_3V3_RAIL(rail), .I_BOOT_GATE_EN(gate_en), .I_SYS_BOOTED(booted),
    .I_PORT0_EVT(evt), .I_STAT_A(stat_a), .I_STAT_B(stat_b), .I_STAT_CHG(chg), .I_SCL(scl),
    .I_SDA(sda_line), .O_SDA_OE(sda_oe), .O_SDA(sda_o), .O_COMPANION_RST_LINE_N(rst_n),
    .O_FLASH_GRANT_COMPANION(grant), .O_IRQ_N(irq_n), .O_SRC_V(src_v), .O_SRC_I(src_i),
    .O_SNK_V(snk_v), .O_SNK_I(snk_i), .O_SBU(sbu));
  sb_companion_model mdl_u (.i_clk(clk), .i_sda_line(sda_line), .o_scl(scl), .o_sda(mdl_sda));
  // Outputs are sampled on falling edges, well settled
  task automatic ticks(input int n);
    repeat (n) @(negedge clk);
  endtask : ticks
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  task automatic t_caps();
    chk({src_v, src_i, snk_i}, {10'h064, 10'h096, 10'h12C});
    chk(snk_v, {10'h190, 10'h12C, 10'h0B4, 10'h064});
  endtask : t_caps
  task automatic t_sbu();
    for (int v = 0; v < 8; v++) begin
      @(posedge clk) evt <= port_evt_s'(v[2:0]);
      ticks(2);
      chk(40'(sbu), {v[2], v[2], v[1], v[0]});
    end
  endtask : t_sbu
  task automatic t_power();
    int n;
    @(posedge clk) rail <= 1'b1;
    ticks(SETTLE + 10);
    chk({rst_n, grant}, 2'b00);
    @(posedge clk) cfg_done <= 1'b1;
    ticks(2);
    chk(grant, 1'b1);
    ticks(SETTLE + 10);
    chk(rst_n, 1'b0);
    @(posedge clk) booted <= 1'b1;
    for (n = 0; rst_n !== 1'b1 && n < 40; n++) ticks(1);
    chk(rst_n, 1'b1);
    @(posedge clk) rail <= 1'b0;
    ticks(10);
    chk(rst_n, 1'b0);
    @(posedge clk) rail <= 1'b1;
    for (n = 0; rst_n !== 1'b1 && n < 200; n++) ticks(1);
    chk(n >= SETTLE && n < SETTLE + 10, 1'b1);
  endtask : t_power
  task automatic t_i2c();
    logic ack;
    logic [7:0] d;
    @(posedge clk) stat_a <= 8'hA5;
    stat_b <= 8'h3C;
    chg <= 1'b1;
    @(posedge clk) chg <= 1'b0;
    ticks(2);
    chk(irq_n, 1'b0);
    // A control write is acked, dropped, and leaves the interrupt alone
    mdl_u.xfer(7'h38, 1'b0, 8'h5A, ack, d);
    chk({ack, irq_n}, 2'b10);
    mdl_u.xfer(7'h38, 1'b1, 8'h00, ack, d);
    chk({ack, d, irq_n}, 10'h34B);
    mdl_u.xfer(7'h3F, 1'b1, 8'h00, ack, d);
    chk({ack, d}, 9'h13C);
    mdl_u.xfer(7'h39, 1'b1, 8'h00, ack, d);
    chk(ack, 1'b0);
    chk({sda_oe, sda_o}, 2'b00);
  endtask : t_i2c
  task automatic t_reset();
    int n;
    // Interrupt pending as reset arrives, so its clear is visible
    @(posedge clk) chg <= 1'b1;
    @(posedge clk) chg <= 1'b0;
    rst <= 1'b1;
    ticks(2);
    chk({rst_n, grant, irq_n, sda_oe, sbu}, 8'h20);
    @(posedge clk) rst <= 1'b0;
    ticks(2);
    chk({rst_n, grant}, 2'b01);
    for (n = 0; rst_n !== 1'b1 && n < 60; n++) ticks(1);
    chk(n >= SETTLE && n < SETTLE + 10, 1'b1);
  endtask : t_reset
  // Main sequence
  initial begin
    ticks(10);
    @(posedge clk) rst <= 1'b0;
    ticks(4);
    t_caps();
    t_sbu();
    t_power();
    t_i2c();
    t_reset();
    complete_run();
  end
  // Watchdog well beyond the expected run length
  initial begin
    ticks(20000);
    miscompares++;
    complete_run();
  end
endmodule : pd_sideband_tb_top
`default_nettype wire
